// ==== pad_phase_divider.sv ====
// Phase accumulator frequency divider with selectable input clock and output shaping.
`include "pad_consts.svh"
`default_nettype none
module pad_phase_divider
  import pad_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Software access
  input wire pad_write_t writeReq,
  input wire pad_ctrl_t ctrl,
  // Asynchronous clock sources
  input wire logic high_freq_internal_osc,
  input wire logic low_freq_internal_osc,
  input wire logic mid_freq_internal_osc_500k,
  input wire logic mid_freq_internal_osc_32k,
  input wire logic reference_clock_out,
  input wire logic logic_cell_one_output,
  input wire logic logic_cell_two_output,
  input wire logic logic_cell_three_output,
  input wire logic logic_cell_four_output,
  // Read back
  output logic [`PAD_ACC_W-1:0] accumValue,
  output logic [`PAD_ACC_W-1:0] stepValue,
  output logic shapedLevel,
  // Events and outputs
  output logic accum_carry_out,
  output logic overflowEvent,
  output logic dividedOut,
  output logic pinOut,
  output logic pinOutEn
);

  // Source synchronisers: three stages, a change counts when stages two and three agree
  logic [`PAD_SRC_N-1:0] srcVec;
  logic [`PAD_SRC_N-1:0] syncA_q, syncB_q, syncC_q, filt_q;
  logic [`PAD_SRC_N-1:0] syncA_d, syncB_d, syncC_d, filt_d;

  assign srcVec = {logic_cell_four_output, logic_cell_three_output, logic_cell_two_output,
                   logic_cell_one_output, reference_clock_out, mid_freq_internal_osc_32k,
                   mid_freq_internal_osc_500k, low_freq_internal_osc, high_freq_internal_osc};

  always_comb begin
    syncA_d = srcVec;
    syncB_d = syncA_q;
    syncC_d = syncB_q;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `PAD_SRC_N; gi++) begin : gFilt
      always_comb begin
        filt_d[gi] = (syncB_q[gi] == syncC_q[gi]) ? syncC_q[gi] : filt_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      syncA_q <= '0;
      syncB_q <= '0;
      syncC_q <= '0;
      filt_q <= '0;
    end else begin
      syncA_q <= syncA_d;
      syncB_q <= syncB_d;
      syncC_q <= syncC_d;
      filt_q <= filt_d;
    end
  end

  // Input clock selection and rising edge detection
  logic selLevel_q, selLevel_d;
  logic selValid;
  logic tick;

  always_comb begin
    selValid = 1'b1;
    selLevel_d = 1'b0;
    case (ctrl.inputClockSelect)
      `PAD_CKS_SYS: selLevel_d = 1'b0;
      `PAD_CKS_HFOSC: selLevel_d = filt_q[0];
      `PAD_CKS_LFOSC: selLevel_d = filt_q[1];
      `PAD_CKS_MF500: selLevel_d = filt_q[2];
      `PAD_CKS_MF32: selLevel_d = filt_q[3];
      `PAD_CKS_REFCLK: selLevel_d = filt_q[4];
      `PAD_CKS_LC1: selLevel_d = filt_q[5];
      `PAD_CKS_LC2: selLevel_d = filt_q[6];
      `PAD_CKS_LC3: selLevel_d = filt_q[7];
      `PAD_CKS_LC4: selLevel_d = filt_q[8];
      default: selValid = 1'b0;
    endcase
    // System clock source ticks every cycle; reserved codes never tick
    if (ctrl.inputClockSelect == `PAD_CKS_SYS) begin
      tick = ctrl.dividerEnable;
    end else begin
      tick = ctrl.dividerEnable & selValid & selLevel_d & ~selLevel_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      selLevel_q <= 1'b0;
    end else begin
      selLevel_q <= selLevel_d;
    end
  end

  // Accumulator, step registers and hidden step buffer
  logic [`PAD_ACC_W-1:0] acc_q, acc_d;
  logic [`PAD_ACC_W-1:0] step_q, step_d;
  logic [`PAD_ACC_W-1:0] stepBuf_q, stepBuf_d;
  logic [1:0] loadCnt_q, loadCnt_d;
  logic loadPend_q, loadPend_d;
  logic carry_q, carry_d;
  logic [`PAD_ACC_W:0] sum;
  logic stepWrite;

  always_comb begin
    acc_d = acc_q;
    step_d = step_q;
    stepBuf_d = stepBuf_q;
    loadCnt_d = loadCnt_q;
    loadPend_d = loadPend_q;
    carry_d = 1'b0;
    sum = {1'b0, acc_q} + {1'b0, stepBuf_q};
    stepWrite = writeReq.valid && (writeReq.target == PAD_STEP_LOW ||
                writeReq.target == PAD_STEP_HIGH || writeReq.target == PAD_STEP_UPPER);
    if (tick) begin
      // Only the carry is dropped, the remainder carries into the next period
      acc_d = sum[`PAD_ACC_W-1:0];
      carry_d = sum[`PAD_ACC_W];
    end
    // A software write to an accumulator byte wins over a same-cycle addition for that byte; the other bytes take the sum
    if (writeReq.valid) begin
      if (writeReq.target == PAD_ACC_LOW) begin
        acc_d[7:0] = writeReq.data;
      end else if (writeReq.target == PAD_ACC_HIGH) begin
        acc_d[15:8] = writeReq.data;
      end else if (writeReq.target == PAD_ACC_UPPER) begin
        acc_d[19:16] = writeReq.data[3:0];
      end else if (writeReq.target == PAD_STEP_LOW) begin
        step_d[7:0] = writeReq.data;
      end else if (writeReq.target == PAD_STEP_HIGH) begin
        step_d[15:8] = writeReq.data;
      end else if (writeReq.target == PAD_STEP_UPPER) begin
        step_d[19:16] = writeReq.data[3:0];
      end
    end
    if (!ctrl.dividerEnable) begin
      loadPend_d = 1'b0;
      loadCnt_d = 2'h0;
      if (stepWrite) begin
        stepBuf_d = step_d;
      end
    end else begin
      if (loadPend_q && tick) begin
        if (loadCnt_q + 2'h1 == `PAD_LOADS_WHEN_ENABLED) begin
          stepBuf_d = step_q;
          loadPend_d = 1'b0;
          loadCnt_d = 2'h0;
        end else begin
          loadCnt_d = loadCnt_q + 2'h1;
        end
      end
      // Only a low byte write arms the transfer; a rewrite restarts the edge count
      if (writeReq.valid && writeReq.target == PAD_STEP_LOW) begin
        loadPend_d = 1'b1;
        loadCnt_d = 2'h0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      acc_q <= `PAD_ACC_RST;
      step_q <= `PAD_ACC_RST;
      stepBuf_q <= `PAD_ACC_RST;
      loadCnt_q <= 2'h0;
      loadPend_q <= 1'b0;
      carry_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      step_q <= step_d;
      stepBuf_q <= stepBuf_d;
      loadCnt_q <= loadCnt_d;
      loadPend_q <= loadPend_d;
      carry_q <= carry_d;
    end
  end

  // Output shaping
  logic shape_q, shape_d;
  logic [`PAD_PW_CNT_W-1:0] pwCnt_q, pwCnt_d;
  logic pin_q, pin_d;
  logic pinEn_q, pinEn_d;
  logic [`PAD_PW_CNT_W-1:0] pwLen;

  always_comb begin
    shape_d = shape_q;
    pwCnt_d = pwCnt_q;
    pwLen = `PAD_PW_CNT_W'(8'h01 << ctrl.pulseWidthSelect) - 8'h01;
    if (!ctrl.pulseModeSelect) begin
      pwCnt_d = `PAD_PW_CNT_RST;
      if (carry_d) begin
        shape_d = ~shape_q;
      end
    end else if (carry_d) begin
      // A new overflow inside a pulse restarts it, so the output stays active
      shape_d = 1'b1;
      pwCnt_d = pwLen;
    end else if (tick && shape_q) begin
      if (pwCnt_q == `PAD_PW_CNT_RST) begin
        shape_d = 1'b0;
      end else begin
        pwCnt_d = pwCnt_q - 8'h01;
      end
    end
    pin_d = shape_d ^ ctrl.polarityInvert;
    pinEn_d = ctrl.pinEnable;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shape_q <= 1'b0;
      pwCnt_q <= `PAD_PW_CNT_RST;
      pin_q <= 1'b0;
      pinEn_q <= 1'b0;
    end else begin
      shape_q <= shape_d;
      pwCnt_q <= pwCnt_d;
      pin_q <= pin_d;
      pinEn_q <= pinEn_d;
    end
  end

  assign accumValue = acc_q;
  assign stepValue = step_q;
  assign shapedLevel = pin_q;
  assign accum_carry_out = carry_q;
  assign overflowEvent = carry_q;
  assign dividedOut = pin_q;
  assign pinOut = pin_q;
  assign pinOutEn = pinEn_q;

endmodule : pad_phase_divider
`default_nettype wire

// ==== pad_consts.svh ====
// Constants of the phase accumulator divider.
`ifndef PAD_CONSTS_SVH
`define PAD_CONSTS_SVH
`define PAD_ACC_W 20
`define PAD_ACC_RST 20'h00000
`define PAD_BYTE_RST 8'h00
`define PAD_PW_CNT_W 8
`define PAD_PW_CNT_RST 8'h00
`define PAD_SRC_N 9
`define PAD_LOADS_WHEN_ENABLED 2'h2
`define PAD_CKS_SYS 4'h0
`define PAD_CKS_HFOSC 4'h1
`define PAD_CKS_LFOSC 4'h2
`define PAD_CKS_MF500 4'h3
`define PAD_CKS_MF32 4'h4
`define PAD_CKS_REFCLK 4'h6
`define PAD_CKS_LC1 4'h7
`define PAD_CKS_LC2 4'h8
`define PAD_CKS_LC3 4'h9
`define PAD_CKS_LC4 4'hA
`endif

// ==== pad_pkg.sv ====
// Types of the phase accumulator divider.
`default_nettype none
package pad_pkg;
  typedef enum logic [2:0] {
    PAD_NONE,
    PAD_ACC_LOW,
    PAD_ACC_HIGH,
    PAD_ACC_UPPER,
    PAD_STEP_LOW,
    PAD_STEP_HIGH,
    PAD_STEP_UPPER
  } pad_target_t;

  typedef struct packed {
    logic valid;
    pad_target_t target;
    logic [7:0] data;
  } pad_write_t;

  typedef struct packed {
    logic dividerEnable;
    logic pulseModeSelect;
    logic polarityInvert;
    logic pinEnable;
    logic [2:0] pulseWidthSelect;
    logic [3:0] inputClockSelect;
  } pad_ctrl_t;
endpackage : pad_pkg
`default_nettype wire

// ==== pad_divider_props.sv ====
// Checker for the phase divider ports.
`default_nettype none
module pad_divider_props
  import pad_pkg::*;
(
  // Clock, reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Inputs
  input wire pad_write_t writeReq,
  input wire pad_ctrl_t ctrl,
  // Outputs
  input wire logic [19:0] accumValue,
  input wire logic [19:0] stepValue,
  input wire logic accum_carry_out,
  input wire logic overflowEvent,
  input wire logic dividedOut,
  input wire logic pinOut,
  input wire logic pinOutEn
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // An overflow can only follow a cycle in which the divider was enabled
  property p_evt;
    overflowEvent == accum_carry_out && (!accum_carry_out || $past(ctrl.dividerEnable));
  endproperty
  a_evt: assert property (p_evt) else $error("event");
  property p_hold; !ctrl.dividerEnable && !writeReq.valid |=> $stable(accumValue); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  // Carry is set exactly when the sum wrapped
  property p_wrap;
    !$past(writeReq.valid) |-> accum_carry_out == (accumValue < $past(accumValue));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap");
  property p_tgl;
    $past(rst_n, 3) && $past(ctrl) == $past(ctrl, 2) && !$past(ctrl.pulseModeSelect)
      |-> (dividedOut != $past(dividedOut)) == accum_carry_out;
  endproperty
  a_tgl: assert property (p_tgl) else $error("toggle");
  property p_pls;
    $past(ctrl.pulseModeSelect) && accum_carry_out |-> dividedOut != $past(ctrl.polarityInvert);
  endproperty
  a_pls: assert property (p_pls) else $error("pulse");
  property p_pin; $past(rst_n) |-> pinOut == dividedOut && pinOutEn == $past(ctrl.pinEnable);
  endproperty
  a_pin: assert property (p_pin) else $error("pin");
  property p_stp;
    writeReq.valid && writeReq.target == PAD_STEP_LOW |=> stepValue[7:0] == $past(writeReq.data);
  endproperty
  a_stp: assert property (p_stp) else $error("step");
  property p_acc;
    writeReq.valid && writeReq.target == PAD_ACC_UPPER
      |=> accumValue[19:16] == $past(writeReq.data[3:0]);
  endproperty
  a_acc: assert property (p_acc) else $error("accum");
endmodule : pad_divider_props
bind pad_phase_divider pad_divider_props u_props (.sys_clk, .rst_n, .writeReq, .ctrl,
  .accumValue, .stepValue, .accum_carry_out, .overflowEvent, .dividedOut, .pinOut, .pinOutEn);
`default_nettype wire

// ==== pad_periph_model.sv ====
// Peripheral that counts rising edges of the divided clock.
`default_nettype none
module pad_periph_model (
  // Clock, reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Divided clock
  input wire logic dividedOut,
  // Tally
  output logic [15:0] riseCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q;
  always_ff @(posedge sys_clk) begin
    last_q <= rst_n & dividedOut;
    riseCount <= !rst_n ? 16'h0000 : riseCount + 16'(dividedOut & !last_q);
  end
endmodule : pad_periph_model
`default_nettype wire

// ==== testbench.sv ====
// Bench for the phase accumulator divider.
`default_nettype none
module testbench
  import pad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, srcTog, carry, evt, divOut, pinOut, pinOutEn, shaped;
  pad_write_t writeReq;
  pad_ctrl_t ctrl;
  logic [8:0] srcMask;
  logic [8:0] srcs;
  logic [19:0] accumValue, stepValue, snap;
  logic [15:0] riseCount;
  int errCount, checksDone, nCarry, nActive, nRise, nShaped;
  assign srcs = srcTog ? srcMask : 9'h000;
  pad_phase_divider DUT (.sys_clk, .rst_n, .writeReq, .ctrl,
    .high_freq_internal_osc(srcs[0]), .low_freq_internal_osc(srcs[1]),
    .mid_freq_internal_osc_500k(srcs[2]), .mid_freq_internal_osc_32k(srcs[3]),
    .reference_clock_out(srcs[4]), .logic_cell_one_output(srcs[5]),
    .logic_cell_two_output(srcs[6]), .logic_cell_three_output(srcs[7]),
    .logic_cell_four_output(srcs[8]), .accumValue, .stepValue, .shapedLevel(shaped),
    .accum_carry_out(carry), .overflowEvent(evt), .dividedOut(divOut), .pinOut, .pinOutEn);
  pad_periph_model PEER (.sys_clk, .rst_n, .dividedOut(divOut), .riseCount);
  task automatic wr(input pad_target_t t, input logic [7:0] d);
    @(negedge sys_clk);
    writeReq <= '{1'b1, t, d};
    @(negedge sys_clk);
    writeReq.valid <= 1'b0;
  endtask : wr
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checksDone++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic tally(input int n);
    nRise = riseCount;
    nCarry = 0;
    nActive = 0;
    nShaped = 0;
    repeat (n) begin
      @(negedge sys_clk);
      nCarry += int'(carry === 1'b1);
      nActive += int'(divOut === !ctrl.polarityInvert);
      nShaped += int'(shaped === !ctrl.polarityInvert);
    end
    nRise = riseCount - nRise;
  endtask : tally
  task automatic wrapUp();
    $display("checks %0d errors %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrapUp
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Slow source clock, sixteen system cycles a period
  initial begin
    srcTog = 1'b0;
    forever begin
      repeat (8) @(negedge sys_clk);
      srcTog = ~srcTog;
    end
  end
  initial begin
    #200000;
    errCount++;
    wrapUp();
  end
  initial begin
    rst_n = 1'b0;
    writeReq = '0;
    ctrl = '0;
    srcMask = 9'h000;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    chk(accumValue, 20'h00000);
    wr(PAD_STEP_UPPER, 8'hF1);
    wr(PAD_STEP_HIGH, 8'h00);
    wr(PAD_STEP_LOW, 8'h00);
    chk(stepValue, 20'h10000);
    wr(PAD_ACC_LOW, 8'hF0);
    wr(PAD_ACC_HIGH, 8'hFF);
    wr(PAD_ACC_UPPER, 8'h0F);
    chk(accumValue, 20'hFFFF0);
    ctrl.dividerEnable = 1'b1;
    tally(160);
    chk(20'(nCarry), 20'h0000A);
    chk(20'(nRise), 20'h00005);
    chk(20'(nActive), 20'h00050);
    chk(20'(nShaped), 20'h00050);
    wr(PAD_STEP_UPPER, 8'h00);
    wr(PAD_STEP_HIGH, 8'h80);
    tally(160);
    chk(20'(nCarry), 20'h0000A);
    chk(stepValue, 20'h08000);
    wr(PAD_STEP_LOW, 8'h00);
    // Two more additions use the old step before the new one takes over
    snap = accumValue;
    repeat (3) @(negedge sys_clk);
    chk(accumValue, snap + 20'h28000);
    @(negedge sys_clk);
    tally(160);
    chk(20'(nCarry), 20'h00005);
    ctrl.pulseModeSelect = 1'b1;
    ctrl.polarityInvert = 1'b1;
    ctrl.pinEnable = 1'b1;
    for (int w = 0; w < 8; w++) begin
      ctrl.pulseWidthSelect = 3'(w);
      repeat (100) @(negedge sys_clk);
      tally(160);
      chk(20'(nActive), w < 5 ? 20'(5 << w) : 20'h000A0);
      chk(20'(nShaped), w < 5 ? 20'(5 << w) : 20'h000A0);
    end
    ctrl = '0;
    wr(PAD_STEP_UPPER, 8'h08);
    wr(PAD_STEP_HIGH, 8'h00);
    wr(PAD_STEP_LOW, 8'h00);
    // For valid codes only the selected source toggles, so a wrong mapping gives no carries; reserved codes toggle every source and expect none
    for (int c = 1; c < 16; c++) begin
      ctrl.dividerEnable = 1'b0;
      ctrl.inputClockSelect = 4'(c);
      srcMask = (c == 5 || c > 10) ? 9'h1FF : 9'h001 << (c < 5 ? c - 1 : c - 2);
      repeat (4) @(negedge sys_clk);
      ctrl.dividerEnable = 1'b1;
      repeat (100) @(negedge sys_clk);
      tally(320);
      chk(20'(nCarry), (c == 5 || c > 10) ? 20'h00000 : 20'h0000A);
    end
    rst_n = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk(stepValue, 20'h00000);
    chk(accumValue, 20'h00000);
    wrapUp();
  end
endmodule : testbench
`default_nettype wire
